// ===== hdl/meas_pkg.sv
// Constants and types for the high-voltage measurement switch control.
// Assumes one clock domain and plain control ports from the register logic.
// Function
// - After reset measurement off, switch open
// - Switch closes only in Normal mode
// - Fail-Safe keeps enable, opens switch
// - Pull currents off while measuring
// - Gate pin signals, clear wake sources
// - Ignore pull/wake settings, accept writes
// - Wake enable writes accepted, not acted
// - Sleep with only pin wakes fails
// - Pin configuration writes flag error
// - Enable refused unless pin is Off
// - Fail output and pin functions unavailable
// - Normal signalling when measurement off
// - Fail-Safe enables sense wake when off
// - Measurement usable only in Normal mode
`default_nettype none
package meas_pkg;
  typedef enum logic [2:0] {
    MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
  } op_mode_t;
  localparam logic [2:0] PIN_CFG_OFF = 3'h0;
  localparam int         PIN_CFG_W   = 3;
  localparam int         MODE_W      = 3;
endpackage
`default_nettype wire

// ===== hdl/meas_gate.sv
// Gating of pin sense signals and pull enables by the measurement state.
// Assumes inputs synchronous to sys_clk.
`default_nettype none
module meas_gate (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic meas_on,
  input  wire logic sense_raw,
  input  wire logic pin_raw,
  input  wire logic pull_req_sense,
  input  wire logic pull_req_pin,
  output logic      sense_gated_ff,
  output logic      pin_gated_ff,
  output logic      pull_sense_ff,
  output logic      pull_pin_ff
);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sense_gated_ff <= 1'b0;
      pin_gated_ff   <= 1'b0;
    end else if (ce) begin
      sense_gated_ff <= sense_raw & ~meas_on;
      pin_gated_ff   <= pin_raw & ~meas_on;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pull_sense_ff <= 1'b0;
      pull_pin_ff   <= 1'b0;
    end else if (ce) begin
      pull_sense_ff <= pull_req_sense & ~meas_on;
      pull_pin_ff   <= pull_req_pin & ~meas_on;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/hv_measurement_switch_ctrl.sv
// Measurement enable, switch control, wake gating and SPI error flagging.
// Assumes mode and write strobes come from the device state machine and SPI.
`default_nettype none
module hv_measurement_switch_ctrl (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic [meas_pkg::MODE_W-1:0]   op_mode,
  input  wire logic                          meas_wr,
  input  wire logic                          meas_wdata,
  input  wire logic                          pin_cfg_wr,
  input  wire logic [meas_pkg::PIN_CFG_W-1:0] pin_cfg_wdata,
  input  wire logic                          sense_wake_enable,
  input  wire logic                          pin_wake_cfg,
  input  wire logic                          other_wake_src,
  input  wire logic                          sleep_cmd,
  input  wire logic                          fail_output_req,
  input  wire logic                          fail_output_test,
  input  wire logic                          pin_func_req,
  input  wire logic                          sense_raw,
  input  wire logic                          pin_raw,
  input  wire logic                          pull_req_sense,
  input  wire logic                          pull_req_pin,
  output logic                               measure_enable_ff,
  output logic                               measure_switch_ff,
  output logic [meas_pkg::PIN_CFG_W-1:0]     pin_cfg_ff,
  output logic                               spi_err_ff,
  output logic                               restart_req_ff,
  output logic                               sleep_go_ff,
  output logic                               sense_wake_act_ff,
  output logic                               pin_wake_act_ff,
  output logic                               fail_output_ff,
  output logic                               pin_func_ff,
  output logic                               sense_gated_ff,
  output logic                               pin_gated_ff,
  output logic                               pull_sense_ff,
  output logic                               pull_pin_ff
);
  logic is_normal;
  logic is_failsafe;
  logic pin_off;
  logic set_refused;
  logic only_pin_wakes;
  logic nxt_err;
  logic sleep_refused;
  logic cfg_blocked;

  // Widths must hold every mode code and the Off code
  if (meas_pkg::MODE_W < $bits(meas_pkg::op_mode_t) ||
      meas_pkg::PIN_CFG_W < $bits(meas_pkg::PIN_CFG_OFF)) begin : g_width_check
    $error("mode or pin config width too narrow");
  end

  // Request survives only while measurement is off
  function automatic logic when_off(input logic req, input logic meas);
    when_off = req & ~meas;
  endfunction

  assign is_normal      = (op_mode == meas_pkg::MODE_NORMAL);
  assign is_failsafe    = (op_mode == meas_pkg::MODE_FAILSAFE);
  assign pin_off        = (pin_cfg_ff == meas_pkg::PIN_CFG_OFF);
  assign set_refused    = meas_wr & meas_wdata & ~measure_enable_ff & ~pin_off;
  assign only_pin_wakes = (sense_wake_enable | pin_wake_cfg) & ~other_wake_src;
  assign sleep_refused  = sleep_cmd & measure_enable_ff & only_pin_wakes;
  assign cfg_blocked    = pin_cfg_wr & measure_enable_ff;

  // Measurement enable bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      measure_enable_ff <= 1'b0;
    end else if (ce && meas_wr) begin
      if (!meas_wdata) begin
        measure_enable_ff <= 1'b0;
      end else if (pin_off) begin
        measure_enable_ff <= 1'b1;
      end
    end
  end

  // Pin configuration, locked while measuring
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_cfg_ff <= meas_pkg::PIN_CFG_OFF;
    end else if (ce && pin_cfg_wr && !measure_enable_ff) begin
      pin_cfg_ff <= pin_cfg_wdata;
    end
  end

  // Switch follows mode, kept enable in other modes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      measure_switch_ff <= 1'b0;
    end else if (ce) begin
      measure_switch_ff <= measure_enable_ff & is_normal;
    end
  end

  // Error flag, sticky until reset
  assign nxt_err = spi_err_ff | set_refused | cfg_blocked | sleep_refused;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      spi_err_ff <= 1'b0;
    end else if (ce) begin
      spi_err_ff <= nxt_err;
    end
  end

  // Sleep command outcome
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      restart_req_ff <= 1'b0;
      sleep_go_ff    <= 1'b0;
    end else if (ce) begin
      restart_req_ff <= sleep_refused;
      sleep_go_ff    <= sleep_cmd & ~sleep_refused;
    end
  end

  // Wake sources, ignored while measuring
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sense_wake_act_ff <= 1'b0;
      pin_wake_act_ff   <= 1'b0;
    end else if (ce) begin
      sense_wake_act_ff <= when_off(sense_wake_enable | is_failsafe, measure_enable_ff);
      pin_wake_act_ff   <= when_off(pin_wake_cfg, measure_enable_ff);
    end
  end

  // Fail output and pin functions, withdrawn while measuring
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fail_output_ff <= 1'b0;
      pin_func_ff    <= 1'b0;
    end else if (ce) begin
      fail_output_ff <= when_off(fail_output_req | fail_output_test, measure_enable_ff);
      pin_func_ff    <= when_off(pin_func_req, measure_enable_ff);
    end
  end

  meas_gate u_gate (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .ce             (ce),
    .meas_on        (measure_enable_ff),
    .sense_raw      (sense_raw),
    .pin_raw        (pin_raw),
    .pull_req_sense (pull_req_sense),
    .pull_req_pin   (pull_req_pin),
    .sense_gated_ff (sense_gated_ff),
    .pin_gated_ff   (pin_gated_ff),
    .pull_sense_ff  (pull_sense_ff),
    .pull_pin_ff    (pull_pin_ff)
  );

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_reset_idle: assert property ($fell(rst) |-> !measure_enable_ff && !measure_switch_ff && !spi_err_ff)
    else $error("state not idle after reset");
  chk_switch_normal: assert property (ce && $past(ce) && measure_switch_ff |-> $past(is_normal))
    else $error("switch closed outside normal mode");
  chk_switch_enable: assert property (ce && $past(ce) && measure_switch_ff |-> $past(measure_enable_ff))
    else $error("switch closed without measurement enabled");
  chk_switch_open_fs: assert property (ce && $past(is_failsafe) && $past(ce) |-> !measure_switch_ff)
    else $error("switch closed in fail-safe");
  chk_enable_kept: assert property (ce && measure_enable_ff && !meas_wr |=> measure_enable_ff)
    else $error("measurement enable lost without a write");
  chk_switch_return: assert property (ce && measure_enable_ff && is_normal |=> measure_switch_ff)
    else $error("switch not closed in normal mode");

  chk_enable_refuse: assert property (ce && set_refused |=> !measure_enable_ff && spi_err_ff)
    else $error("enable set while pin not off");
  chk_disable: assert property (ce && meas_wr && !meas_wdata |=> !measure_enable_ff)
    else $error("measurement not disabled by write");
  chk_cfg_write: assert property (ce && pin_cfg_wr && !measure_enable_ff
                                  |=> pin_cfg_ff == $past(pin_cfg_wdata))
    else $error("pin config write lost");
  chk_cfg_locked: assert property (ce && cfg_blocked |=> $stable(pin_cfg_ff))
    else $error("pin config changed while measuring");
  chk_cfg_err: assert property (ce && cfg_blocked |=> spi_err_ff)
    else $error("pin config write while measuring not flagged");
  chk_err_sticky: assert property (ce && spi_err_ff |=> spi_err_ff)
    else $error("error flag dropped");

  chk_sleep_fail: assert property (ce && sleep_refused |=> restart_req_ff && !sleep_go_ff)
    else $error("sleep not refused");
  chk_sleep_pass: assert property (ce && sleep_cmd && !sleep_refused |=> sleep_go_ff && !restart_req_ff)
    else $error("allowed sleep not passed");
  chk_sleep_idle: assert property (ce && !sleep_cmd |=> !restart_req_ff && !sleep_go_ff)
    else $error("sleep result without command");

  chk_pull_off: assert property (ce && measure_enable_ff |=> !pull_sense_ff && !pull_pin_ff)
    else $error("pull active while measuring");
  chk_pull_pass: assert property (ce && !measure_enable_ff
                                  |=> pull_sense_ff == $past(pull_req_sense) && pull_pin_ff == $past(pull_req_pin))
    else $error("pull setting not applied");
  chk_gate_sig: assert property (ce && measure_enable_ff |=> !sense_gated_ff && !pin_gated_ff)
    else $error("pin signal passed while measuring");
  chk_gate_pass: assert property (ce && !measure_enable_ff
                                  |=> sense_gated_ff == $past(sense_raw) && pin_gated_ff == $past(pin_raw))
    else $error("pin signal lost while not measuring");
  chk_fo_off: assert property (ce && measure_enable_ff |=> !fail_output_ff && !pin_func_ff)
    else $error("pin function active while measuring");
  chk_wake_off: assert property (ce && measure_enable_ff |=> !pin_wake_act_ff && !sense_wake_act_ff)
    else $error("wake source active while measuring");
  chk_fo_pass: assert property (ce && !measure_enable_ff
                                |=> fail_output_ff == $past(fail_output_req | fail_output_test))
    else $error("fail output request lost");
  chk_pin_wake_pass: assert property (ce && !measure_enable_ff
                                      |=> pin_wake_act_ff == $past(pin_wake_cfg))
    else $error("pin wake setting lost");
  chk_sense_wake_pass: assert property (ce && !measure_enable_ff && sense_wake_enable |=> sense_wake_act_ff)
    else $error("sense wake setting lost");
  chk_fs_wake: assert property (ce && !measure_enable_ff && is_failsafe |=> sense_wake_act_ff)
    else $error("fail-safe sense wake missing");

  cov_switch_close: cover property (ce && measure_enable_ff && is_normal ##1 measure_switch_ff);
  cov_refuse: cover property (ce && set_refused);
  cov_sleep_fail: cover property (restart_req_ff);
  cov_fs_hold: cover property (ce && measure_enable_ff && is_failsafe);
  cov_cfg_block: cover property (ce && cfg_blocked);
endmodule
`default_nettype wire

// ===== verif/host_model.sv
// Host side: issues enable, pin and sleep writes and sets the mode.
// Assumes a free running sys_clk; requests last one cycle.
`default_nettype none
module host_model (
  input  wire logic       sys_clk,
  output logic [2:0]      op_mode,
  output logic            meas_wr,
  output logic            meas_wdata,
  output logic            pin_cfg_wr,
  output logic [2:0]      pin_cfg_wdata,
  output logic            sleep_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {op_mode, meas_wr, meas_wdata, pin_cfg_wr, pin_cfg_wdata, sleep_cmd} = '0;
  end
  // Drives one request at a clock edge and drops the write and sleep strobes at the next; mode is held
  task automatic pulse(input int k, input logic [2:0] v);
    @(posedge sys_clk);
    case (k)
      0: {meas_wr, meas_wdata} <= {1'b1, v[0]};
      1: {pin_cfg_wr, pin_cfg_wdata} <= {1'b1, v};
      2: sleep_cmd <= 1'b1;
      default: op_mode <= v;
    endcase
    @(posedge sys_clk);
    {meas_wr, pin_cfg_wr, sleep_cmd} <= 3'h0;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the measurement switch control.
// Assumes host_model drives writes; expectations queue for a watcher.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [12:0] f; logic [12:0] m; logic [2:0] c;} note_t;
  logic        sys_clk = 0, rst = 1, pwk = 1, oth = 1, e_en, e_err;
  logic [7:0]  rnd = 0;
  logic [2:0]  e_cfg;
  wire logic [2:0]  mode, cwd, cfg;
  wire logic        mwr, mwd, cwr, slp;
  wire logic [12:0] got;
  int          miscompares = 0, check_count = 0;
  note_t       notes[$], cur;
  initial forever #12.5 sys_clk = ~sys_clk;
  host_model host (.sys_clk(sys_clk), .op_mode(mode), .meas_wr(mwr), .meas_wdata(mwd),
    .pin_cfg_wr(cwr), .pin_cfg_wdata(cwd), .sleep_cmd(slp));
  hv_measurement_switch_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .op_mode(mode),
    .meas_wr(mwr), .meas_wdata(mwd), .pin_cfg_wr(cwr), .pin_cfg_wdata(cwd),
    .sense_wake_enable(rnd[7]), .pin_wake_cfg(pwk), .other_wake_src(oth), .sleep_cmd(slp),
    .fail_output_req(rnd[4]), .fail_output_test(rnd[5]), .pin_func_req(rnd[6]),
    .sense_raw(rnd[1]), .pin_raw(rnd[0]), .pull_req_sense(rnd[3]), .pull_req_pin(rnd[2]),
    .measure_enable_ff(got[12]), .measure_switch_ff(got[11]), .pin_cfg_ff(cfg),
    .spi_err_ff(got[10]), .restart_req_ff(got[9]), .sleep_go_ff(got[8]),
    .sense_wake_act_ff(got[3]), .pin_wake_act_ff(got[0]), .fail_output_ff(got[2]),
    .pin_func_ff(got[1]), .sense_gated_ff(got[5]), .pin_gated_ff(got[4]),
    .pull_sense_ff(got[7]), .pull_pin_ff(got[6]));
  task automatic note(input logic r, g, z);
    note_t n;
    n.f = z ? '0 : {e_en, e_en & (mode == meas_pkg::MODE_NORMAL), e_err, r, g, {4{~e_en}} & rnd[3:0],
      ~e_en & (rnd[7] | mode == meas_pkg::MODE_FAILSAFE), {3{~e_en}} & {rnd[4] | rnd[5], rnd[6], pwk}};
    n.m = '1;
    n.c = z ? '0 : e_cfg;
    notes.push_back(n);
  endtask
  task automatic step(input int k, input logic [2:0] v, input int n);
    logic f;
    @(posedge sys_clk);
    rnd <= 8'($urandom);
    host.pulse(k, v);
    f = e_en & !oth & (rnd[7] | pwk);
    case (k)
      0: if (v[0] & !e_en & e_cfg != 3'h0) e_err = 1; else e_en = v[0];
      1: if (e_en) e_err = 1; else e_cfg = v;
      2: e_err = e_err | f;
      default: ;
    endcase
    repeat (n) @(posedge sys_clk);
    note(k == 2 && f, k == 2 && !f, 0);
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    {e_en, e_err, e_cfg} = '0;
    note(0, 0, 1);
  endtask
  task automatic cmp_flags(input logic [12:0] e, m);
    check_count++;
    if (((got ^ e) & m) !== 13'h0) begin
      miscompares++;
      $display("MISMATCH flags expected %h seen %h", e, got & m);
    end
  endtask
  task automatic cmp_cfg(input logic [2:0] e);
    check_count++;
    if (cfg !== e) begin
      miscompares++;
      $display("MISMATCH pin_cfg expected %h seen %h", e, cfg);
    end
  endtask
  always @(negedge sys_clk) begin
    if (notes.size() > 0) begin
      cur = notes.pop_front();
      cmp_flags(cur.f, cur.m);
      cmp_cfg(cur.c);
    end
  end
  task automatic final_report();
    for (int i = 0; i < 4 && notes.size() > 0; i++) @(posedge sys_clk);
    if (notes.size() > 0) miscompares++;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end
  initial begin
    void'($urandom(32'h46c0));
    do_reset();
    step(3, 3'h1, 1);
    step(1, 3'h1 + 3'($urandom_range(6)), 1);
    step(0, 3'h1, 1);
    $display("refused enable test done");
    do_reset();
    step(0, 3'h1, 1);
    for (int i = 2; i < 6; i++) begin
      step(3, 3'(i), 1);
      step(3, 3'h1, 1);
    end
    step(2, 3'h0, 0);
    oth <= 1'b0;
    step(2, 3'h0, 0);
    $display("mode and sleep test done");
    do_reset();
    pwk <= 1'b0;
    step(0, 3'h1, 1);
    step(1, 3'h2, 1);
    step(0, 3'h0, 1);
    step(3, 3'h5, 1);
    step(3, 3'h1, 1);
    $display("pin write and disable test done");
    final_report();
  end
endmodule
`default_nettype wire
